// ===== rtl/nfc_active_p2p_field_sequencer.sv
/*
 * Field and link sequencer for active peer-to-peer communication, initiator
 * and target, with an AXI4-Lite register slave. Assumes the field detector
 * pin is asynchronous, and that rx_start, rate_valid, rate_code and tx_done
 * come from receiver and framer logic on clk.
 */
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Operation
// [R1] One shared bit rate for transmit and receive.
// [R2] Host clears role bit initiator, sets target.
// [R3] Preset enables amplitude channel, disables phase.
// [R4] Preset sets transport frame enable.
// [R5] Active or target mode enables field detector.
// [R6] Collision threshold during field-on, otherwise peer.
// [R7] Only field-on commands set transmitter enable.
// [R8] Field off after message, general timer delay.
// [R9] Auto response starts collision avoidance on loss.
// [R10] Host keeps response count zero while looping.
// [R11] Response periods taken from response count bits.
// [R12] Initial field-on: field on, done after guard.
// [R13] After field off, no-response timer, timeout interrupt.
// [R14] Peer field: interrupt, mask timer, then receive.
// [R15] Field loss interrupt; auto response uses active guard.
// [R16] Host clears auto response before final command.
// [R17] Target with operation bits zero: low power.
// [R18] Target rate detection or programmed normal rate.
// [R19] Detect rate, interrupt, load; gate auto response.
// [R20] Go-normal copies detected rate, leaves detection.
// [R21] Host powers up, then starts mask timer.
// [R22] Host returns to low power after last reply.
// [R23] Collision seen: interrupt, field stays off.
// [R24] Transport frame sends start byte then length.
// [R25] Flags latch until status read; line follows.
module nfc_active_p2p_field_sequencer (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic field_detect,
    input wire logic rx_start,
    input wire logic rate_valid,
    input wire logic [1:0] rate_code,
    input wire logic tx_done,
    output logic tx_enable,
    output logic field_detector_enable,
    output logic ca_threshold_select,
    output logic transport_frame_enable,
    output logic am_channel_enable,
    output logic pm_channel_enable,
    output logic [1:0] bit_rate,
    output logic rx_observe,
    output logic low_power,
    output logic [7:0] tx_byte,
    output logic tx_byte_valid,
    output logic tx_payload_go,
    output logic irq
);
    import nfc_p2p_pkg::*;

    typedef struct packed {
        seq_state_e st;
        logic [15:0] cnt;
        logic [1:0] rca_left;
        logic resp_seq;
        logic fd1;
        logic fd2;
        logic fdp;
        logic target;
        logic auto_ar;
        logic rate_detect;
        logic active;
        logic [1:0] rate;
        logic [2:0] opc;
        logic txen;
        logic [1:0] rcount;
        logic fden;
        logic tfe;
        logic am;
        logic pm;
        logic [15:0] gpt;
        logic [15:0] nrt;
        logic [15:0] mrt;
        logic [7:0] flags;
        logic [7:0] imask;
        logic [1:0] detrate;
        logic rate_ok;
        logic [7:0] txlen;
        logic [1:0] pfx;
        logic [7:0] txb;
        logic txbv;
        logic txgo;
        logic rxobs;
        logic thr;
        logic lowp;
        logic irqo;
        logic awf;
        logic wf;
        logic [7:0] awa;
        logic [31:0] wd;
        logic [3:0] ws;
        logic awr;
        logic wr;
        logic bv;
        logic [1:0] br;
        logic arr;
        logic rv;
        logic [1:0] rr;
        logic [31:0] rd;
    } seq_s;

    seq_s q;
    seq_s n;

    function automatic logic [32:0] reg_value(input seq_s s, input logic [7:0] a);
        logic [32:0] v;
        v = {1'b0, 32'h0};
        unique case (a)
            OFS_MODE: v[5:0] = {s.active, s.rate, s.rate_detect, s.auto_ar, s.target};
            OFS_OPCTRL: v[3:0] = {s.txen, s.opc};
            OFS_AUX: v[5:0] = {s.pm, s.am, s.tfe, s.fden, s.rcount};
            OFS_CMD: v = {1'b0, 32'h0};
            OFS_GPT: v[15:0] = s.gpt;
            OFS_NRT: v[15:0] = s.nrt;
            OFS_MRT: v[15:0] = s.mrt;
            OFS_IRQ: v[7:0] = s.flags;
            OFS_IMASK: v[7:0] = s.imask;
            OFS_DETRATE: v[2:0] = {s.rate_ok, s.detrate};
            OFS_STATUS: v[9:0] = {s.thr, s.txen, s.st};
            OFS_TXLEN: v[7:0] = s.txlen;
            default: v[32] = 1'b1;
        endcase
        return v;
    endfunction : reg_value

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] w,
                                          input logic [3:0] m);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (m[i]) begin
                r[8*i +: 8] = w[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    always_comb begin
        logic [7:0] ev;
        logic [3:0] cmd;
        logic [32:0] rv;
        logic [31:0] m;
        logic rise;
        logic fall;
        logic auto_ok;
        logic cnt_done;
        n = q;
        ev = 8'h00;
        cmd = 4'h0;
        rv = {1'b0, 32'h0};
        m = 32'h0;
        n.txgo = 1'b0;
        n.txbv = 1'b0;
        n.fd1 = field_detect;
        n.fd2 = q.fd1;
        n.fdp = q.fd2;
        rise = q.fd2 & ~q.fdp;
        fall = ~q.fd2 & q.fdp;
        cnt_done = (q.cnt == 16'h0);
        if (!cnt_done) begin
            n.cnt = q.cnt - 16'h1;
        end
        // [R9] Auto response gate.
        // [R19] Rate detected first.
        auto_ok = q.auto_ar & (~q.target | ~q.rate_detect | q.rate_ok);
        if (q.awr && s_axi_awvalid) begin
            n.awf = 1'b1;
            n.awa = s_axi_awaddr;
        end
        if (q.wr && s_axi_wvalid) begin
            n.wf = 1'b1;
            n.wd = s_axi_wdata;
            n.ws = s_axi_wstrb;
        end
        if (q.bv && s_axi_bready) begin
            n.bv = 1'b0;
        end
        if (q.awf && q.wf && !q.bv) begin
            rv = reg_value(q, q.awa);
            m = merge(rv[31:0], q.wd, q.ws);
            n.awf = 1'b0;
            n.wf = 1'b0;
            n.bv = 1'b1;
            n.br = rv[32] ? RESP_SLVERR : RESP_OKAY;
            unique case (q.awa)
                OFS_MODE: begin
                    {n.active, n.rate, n.rate_detect, n.auto_ar, n.target} = m[5:0];
                    // [R5] Detector auto enable.
                    if (m[MODE_ACTIVE] || m[MODE_TARGET]) begin
                        n.fden = 1'b1;
                    end
                    if (m[MODE_RATE_DETECT]) begin
                        n.rate_ok = 1'b0;
                    end
                end
                // [R7] Transmitter bit protected.
                OFS_OPCTRL: n.opc = m[2:0];
                OFS_AUX: {n.pm, n.am, n.tfe, n.fden, n.rcount} = m[5:0];
                OFS_CMD: cmd = q.ws[0] ? q.wd[3:0] : 4'h0;
                OFS_GPT: n.gpt = m[15:0];
                OFS_NRT: n.nrt = m[15:0];
                OFS_MRT: n.mrt = m[15:0];
                OFS_IMASK: n.imask = m[7:0];
                OFS_TXLEN: n.txlen = m[7:0];
                default: n.br = rv[32] ? RESP_SLVERR : RESP_OKAY;
            endcase
        end
        n.awr = ~n.awf;
        n.wr = ~n.wf;
        if (q.rv && s_axi_rready) begin
            n.rv = 1'b0;
        end
        if (q.arr && s_axi_arvalid) begin
            rv = reg_value(q, s_axi_araddr);
            n.rv = 1'b1;
            n.rd = rv[31:0];
            n.rr = rv[32] ? RESP_SLVERR : RESP_OKAY;
            // [R25] Read clears flags.
            if (s_axi_araddr == OFS_IRQ) begin
                n.flags = 8'h00;
            end
        end
        n.arr = ~n.rv;
        // [R3] Amplitude channel only.
        // [R4] Transport frame on.
        if (cmd == CMD_ANALOG_PRESET && (q.active || q.target)) begin
            n.am = 1'b1;
            n.pm = 1'b0;
            n.tfe = 1'b1;
        end
        // [R20] Copy detected rate.
        if (cmd == CMD_GO_NORMAL) begin
            n.rate = q.detrate;
            n.rate_detect = 1'b0;
        end
        // [R18] Measure initiator rate.
        // [R19] Load and flag.
        if (q.target && q.rate_detect && q.rxobs && rate_valid) begin
            n.detrate = rate_code;
            n.rate_ok = 1'b1;
            ev[IRQ_NFCT] = 1'b1;
        end
        if (q.rxobs && rx_start) begin
            ev[IRQ_SOR] = 1'b1;
        end
        // [R24] Start byte then length.
        unique case (q.pfx)
            2'h1: begin
                n.txbv = 1'b1;
                n.txb = START_BYTE;
                n.pfx = 2'h2;
            end
            2'h2: begin
                n.txbv = 1'b1;
                n.txb = q.txlen + 8'h1;
                n.pfx = 2'h3;
            end
            2'h3: begin
                n.txgo = 1'b1;
                n.pfx = 2'h0;
            end
            default: n.pfx = 2'h0;
        endcase
        unique case (q.st)
            ST_IDLE: begin
                if (cmd == CMD_INITIAL_FIELD_ON) begin
                    n.st = ST_CA;
                    n.cnt = CA_CYC;
                    n.rca_left = 2'h0;
                    n.resp_seq = 1'b0;
                end else if (cmd == CMD_RESPONSE_FIELD_ON) begin
                    // [R11] Response period count.
                    n.st = ST_CA;
                    n.cnt = CA_CYC;
                    n.rca_left = q.rcount;
                    n.resp_seq = 1'b1;
                end else if (cmd == CMD_START_MASK_RX) begin
                    n.st = ST_MASK;
                    n.cnt = q.mrt;
                end
                if (rise) begin
                    ev[IRQ_EON] = 1'b1;
                end
                if (fall) begin
                    ev[IRQ_EOF] = 1'b1;
                    if (auto_ok) begin
                        n.st = ST_CA;
                        n.cnt = CA_CYC;
                        n.rca_left = q.rcount;
                        n.resp_seq = 1'b1;
                    end
                end
            end
            ST_CA: begin
                // [R23] Collision keeps field off.
                if (q.fd2) begin
                    ev[IRQ_CAC] = 1'b1;
                    n.st = ST_IDLE;
                end else if (cnt_done) begin
                    if (q.rca_left != 2'h0) begin
                        n.rca_left = q.rca_left - 2'h1;
                        n.cnt = RCA_CYC;
                    end else begin
                        // [R12] Field switched on.
                        n.txen = 1'b1;
                        n.st = ST_GUARD;
                        n.cnt = q.resp_seq ? AGT_CYC : IGT_CYC;
                    end
                end
            end
            ST_GUARD: begin
                // [R12] Guard then done flag.
                if (cnt_done) begin
                    ev[IRQ_CAT] = 1'b1;
                    n.st = ST_TXON;
                end
            end
            ST_TXON: begin
                if (cmd == CMD_TRANSMIT) begin
                    n.pfx = q.tfe ? 2'h1 : 2'h3;
                end
                if (tx_done) begin
                    n.st = ST_HOLD;
                    n.cnt = q.gpt;
                end
            end
            ST_HOLD: begin
                // [R8] Timed field off.
                if (cnt_done) begin
                    n.txen = 1'b0;
                    ev[IRQ_GPT] = 1'b1;
                    n.st = ST_NRTW;
                    n.cnt = q.nrt;
                end
            end
            ST_NRTW: begin
                // [R13] No-response timeout.
                if (rise) begin
                    ev[IRQ_EON] = 1'b1;
                    n.st = ST_MASK;
                    n.cnt = q.mrt;
                end else if (cnt_done) begin
                    ev[IRQ_NRT] = 1'b1;
                    n.st = ST_IDLE;
                end
            end
            ST_MASK: begin
                // [R14] Mask then observe.
                if (cnt_done) begin
                    n.st = ST_PEER;
                end
            end
            ST_PEER: begin
                // [R15] Peer field loss.
                if (fall) begin
                    ev[IRQ_EOF] = 1'b1;
                    n.st = ST_IDLE;
                    if (auto_ok) begin
                        n.st = ST_CA;
                        n.cnt = CA_CYC;
                        n.rca_left = q.rcount;
                        n.resp_seq = 1'b1;
                    end
                end
            end
            default: n.st = ST_IDLE;
        endcase
        // [R25] Set wins over clear.
        n.flags = n.flags | ev;
        n.irqo = |(n.flags & n.imask);
        n.rxobs = (n.st == ST_PEER);
        // [R6] Threshold selection.
        n.thr = (n.st == ST_CA) || (n.st == ST_GUARD);
        // [R17] Low power target.
        n.lowp = n.target && (n.opc == 3'h0) && (n.st == ST_IDLE);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '{st: ST_IDLE, awr: 1'b1, wr: 1'b1, arr: 1'b1, default: '0};
        end else if (clk_en) begin
            q <= n;
        end
    end

    assign s_axi_awready = q.awr;
    assign s_axi_wready = q.wr;
    assign s_axi_bresp = q.br;
    assign s_axi_bvalid = q.bv;
    assign s_axi_arready = q.arr;
    assign s_axi_rdata = q.rd;
    assign s_axi_rresp = q.rr;
    assign s_axi_rvalid = q.rv;
    assign tx_enable = q.txen;
    assign field_detector_enable = q.fden;
    assign ca_threshold_select = q.thr;
    assign transport_frame_enable = q.tfe;
    assign am_channel_enable = q.am;
    assign pm_channel_enable = q.pm;
    // [R1] Same rate both directions.
    assign bit_rate = q.rate;
    assign rx_observe = q.rxobs;
    assign low_power = q.lowp;
    assign tx_byte = q.txb;
    assign tx_byte_valid = q.txbv;
    assign tx_payload_go = q.txgo;
    assign irq = q.irqo;
endmodule : nfc_active_p2p_field_sequencer

// ===== rtl/nfc_p2p_pkg.sv
/*
 * Constants shared by the active peer-to-peer field sequencer: register map,
 * field positions, commands, interrupt flag positions, sequencer states and
 * guard and collision avoidance times. Assumes a 250 MHz system clock.
 */
package nfc_p2p_pkg;
    localparam int CLK_PERIOD_NS = 4;
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_OPCTRL = 8'h04;
    localparam logic [7:0] OFS_AUX = 8'h08;
    localparam logic [7:0] OFS_CMD = 8'h0c;
    localparam logic [7:0] OFS_GPT = 8'h10;
    localparam logic [7:0] OFS_NRT = 8'h14;
    localparam logic [7:0] OFS_MRT = 8'h18;
    localparam logic [7:0] OFS_IRQ = 8'h1c;
    localparam logic [7:0] OFS_IMASK = 8'h20;
    localparam logic [7:0] OFS_DETRATE = 8'h24;
    localparam logic [7:0] OFS_STATUS = 8'h28;
    localparam logic [7:0] OFS_TXLEN = 8'h2c;
    localparam int MODE_TARGET = 0;
    localparam int MODE_AUTO_AR = 1;
    localparam int MODE_RATE_DETECT = 2;
    localparam int MODE_RATE_LSB = 3;
    localparam int MODE_ACTIVE = 5;
    localparam int OPC_TXEN = 3;
    localparam int AUX_FDEN = 2;
    localparam int AUX_TFE = 3;
    localparam int AUX_AM = 4;
    localparam int AUX_PM = 5;
    localparam logic [3:0] CMD_ANALOG_PRESET = 4'h1;
    localparam logic [3:0] CMD_INITIAL_FIELD_ON = 4'h2;
    localparam logic [3:0] CMD_RESPONSE_FIELD_ON = 4'h3;
    localparam logic [3:0] CMD_START_MASK_RX = 4'h4;
    localparam logic [3:0] CMD_GO_NORMAL = 4'h5;
    localparam logic [3:0] CMD_TRANSMIT = 4'h6;
    localparam int IRQ_CAT = 0;
    localparam int IRQ_CAC = 1;
    localparam int IRQ_EON = 2;
    localparam int IRQ_EOF = 3;
    localparam int IRQ_NRT = 4;
    localparam int IRQ_GPT = 5;
    localparam int IRQ_SOR = 6;
    localparam int IRQ_NFCT = 7;
    localparam logic [1:0] RATE_FC128 = 2'h0;
    localparam logic [1:0] RATE_FC64 = 2'h1;
    localparam logic [1:0] RATE_FC32 = 2'h2;
    localparam logic [7:0] START_BYTE = 8'hf0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int INITIAL_GUARD_TIME_NS = 5000;
    localparam int ACTIVE_GUARD_TIME_NS = 1000;
    localparam int CA_TIME_NS = 1000;
    localparam int RCA_PERIOD_NS = 500;
    localparam logic [15:0] IGT_CYC = 16'((INITIAL_GUARD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] AGT_CYC = 16'((ACTIVE_GUARD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] CA_CYC = 16'((CA_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] RCA_CYC = 16'((RCA_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_CA = 8'h02,
        ST_GUARD = 8'h04,
        ST_TXON = 8'h08,
        ST_HOLD = 8'h10,
        ST_NRTW = 8'h20,
        ST_MASK = 8'h40,
        ST_PEER = 8'h80
    } seq_state_e;
endpackage : nfc_p2p_pkg

// ===== tb/nfc_seq_chk.sv
/* Checker for the field sequencer ports.
   Assumes clk_en is held high. */
`timescale 1ns/1ps
module nfc_seq_chk (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic tx_enable,
    input wire logic ca_threshold_select,
    input wire logic rx_observe,
    input wire logic low_power,
    input wire logic [7:0] tx_byte,
    input wire logic tx_byte_valid,
    input wire logic tx_payload_go
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    rd_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    wr_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    field_on_a: assert property ($rose(tx_enable) |-> $past(ca_threshold_select))
        else $error("field on outside field-on command");
    guard_a: assert property ($rose(tx_enable) |-> (tx_enable && ca_threshold_select)[*8])
        else $error("guard time cut short");
    observe_a: assert property (rx_observe |-> !tx_enable && !ca_threshold_select)
        else $error("bad state while receiving");
    frame_a: assert property (tx_byte_valid && tx_byte == 8'hf0 |=> tx_byte_valid ##1 tx_payload_go)
        else $error("frame prefix broken");
    low_power_a: assert property (low_power |-> !tx_enable && !rx_observe)
        else $error("activity in low power state");
    cover property ($rose(tx_enable));
    cover property ($rose(rx_observe));
    cover property (tx_byte_valid);
endmodule : nfc_seq_chk

// ===== tb/peer_device_model.sv
/* Peer device and framer stand-in: field seen after a lag, message end.
   Assumes peer_on comes from the bench on clk. */
`timescale 1ns/1ps
module peer_device_model #(parameter int LAG = 3, parameter int MSG = 6) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic peer_on,
    input wire logic tx_payload_go,
    output logic field_detect,
    output logic tx_done
);
    logic [LAG-1:0] lag_q;
    int cnt_q;
    assign field_detect = lag_q[LAG-1];
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lag_q <= '0;
            cnt_q <= 0;
            tx_done <= 1'b0;
        end else begin
            lag_q <= {lag_q[LAG-2:0], peer_on};
            tx_done <= (cnt_q == 1);
            if (tx_payload_go) cnt_q <= MSG;
            else if (cnt_q != 0) cnt_q <= cnt_q - 1;
        end
    end
endmodule : peer_device_model

// ===== tb/nfc_active_p2p_field_sequencer_tb_top.sv
/* Bench for the field sequencer: AXI4-Lite host tasks and scenarios.
   Assumes the peer model supplies field and message end. */
`timescale 1ns/1ps
module nfc_active_p2p_field_sequencer_tb_top;
    import nfc_p2p_pkg::*;
    logic clk, reset_n, awv, wv, bready, arv, rready, peer_on, rx_start, rate_valid;
    logic awr, wrdy, bv, arr, rv, fd, txd, txe, fde, cts, tfe, ame, pme, rxo, lp, tbv, go, irq;
    logic [1:0] bresp, rresp, rate_code, rate;
    logic [31:0] wdata, rdata;
    logic [7:0] awa, ara, tb;
    logic [3:0] wstrb;
    logic [7:0] sent[$];
    int n_mismatch, n_compared, cycles;
    nfc_active_p2p_field_sequencer dut (.clk(clk), .reset_n(reset_n), .clk_en(1'b1),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rready), .field_detect(fd), .rx_start(rx_start),
        .rate_valid(rate_valid), .rate_code(rate_code), .tx_done(txd), .tx_enable(txe),
        .field_detector_enable(fde), .ca_threshold_select(cts),
        .transport_frame_enable(tfe), .am_channel_enable(ame), .pm_channel_enable(pme),
        .bit_rate(rate), .rx_observe(rxo), .low_power(lp), .tx_byte(tb),
        .tx_byte_valid(tbv), .tx_payload_go(go), .irq(irq));
    peer_device_model peer (.clk(clk), .reset_n(reset_n), .peer_on(peer_on),
        .tx_payload_go(go), .field_detect(fd), .tx_done(txd));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        if (tbv) sent.push_back(tb);
        cycles++;
        if (cycles == 40000) begin
            n_mismatch++;
            final_report();
        end
    end
    task automatic final_report();
        $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        @(posedge clk);
        awa <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
            if (bv) break;
        end
        bready <= 1'b0;
        chk(32'(bresp), 32'(er));
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            if (rv) break;
        end
        rready <= 1'b0;
        chk(32'(rresp), 32'(er));
        chk(rdata, exp);
    endtask : rd
    function automatic logic sig(input int k);
        case (k)
            0: return txe;
            1: return irq;
            2: return rxo;
            default: return lp;
        endcase
    endfunction : sig
    task automatic wait_on(input int k, input logic v);
        #1;
        for (int n = 0; n < 4000 && sig(k) !== v; n++) begin
            @(posedge clk);
            #1;
        end
        chk(32'(sig(k)), 32'(v));
    endtask : wait_on
    task automatic s_regs();
        rd(OFS_MODE, 32'h0);
        rd(OFS_STATUS, 32'(ST_IDLE));
        rd(8'h40, 32'h0, RESP_SLVERR);
        wr(8'h40, 32'h1, RESP_SLVERR);
        wr(OFS_OPCTRL, 32'h8);
        rd(OFS_OPCTRL, 32'h0); // Bit stays clear.
        wr(OFS_AUX, 32'h20); // Count bits zero.
        wr(OFS_MODE, 32'h22); // Initiator with auto response.
        rd(OFS_AUX, 32'h24); // Detector switched on.
        wr(OFS_CMD, 32'(CMD_ANALOG_PRESET));
        rd(OFS_AUX, 32'h1c); // Amplitude channel only.
        chk(32'({ame, pme, tfe, fde}), 32'hb); // Frame format set.
        wr(OFS_GPT, 32'h5);
        wr(OFS_NRT, 32'h28);
        wr(OFS_MRT, 32'h5);
        wr(OFS_TXLEN, 32'h3);
        wr(OFS_IMASK, 32'hff);
    endtask : s_regs
    task automatic s_initiator();
        wr(OFS_CMD, 32'(CMD_INITIAL_FIELD_ON));
        wait_on(0, 1'b1);
        chk(32'(cts), 32'h1); // Collision threshold used.
        wait_on(1, 1'b1);
        rd(OFS_IRQ, 32'h1); // Done after guard.
        wr(OFS_CMD, 32'(CMD_TRANSMIT));
        wait_on(0, 1'b0);
        rd(OFS_IRQ, 32'h20); // Field off after message.
        @(posedge clk) peer_on <= 1'b1;
        wait_on(2, 1'b1); // Receive after mask time.
        rd(OFS_IRQ, 32'h4); // Peer field seen.
        @(posedge clk) peer_on <= 1'b0;
        wait_on(0, 1'b1); // Response started alone.
        repeat (AGT_CYC + 8) @(posedge clk);
        rd(OFS_IRQ, 32'h9); // Loss and guard done.
        wr(OFS_MODE, 32'h20); // Auto response off.
        wr(OFS_CMD, 32'(CMD_TRANSMIT));
        wait_on(0, 1'b0);
        repeat (48) @(posedge clk);
        rd(OFS_IRQ, 32'h30); // No reply timeout.
        rd(OFS_STATUS, 32'(ST_IDLE)); // Field stays off.
        chk(32'(sent.size()), 32'h4);
        foreach (sent[i]) chk(32'(sent[i]), (i % 2) ? 32'h4 : 32'(START_BYTE));
    endtask : s_initiator
    task automatic s_collision();
        @(posedge clk) peer_on <= 1'b1;
        wait_on(1, 1'b1);
        rd(OFS_IRQ, 32'h4);
        wr(OFS_CMD, 32'(CMD_INITIAL_FIELD_ON));
        wait_on(1, 1'b1);
        rd(OFS_IRQ, 32'h2); // Collision reported.
        chk(32'(txe), 32'h0); // Field kept off.
        @(posedge clk) peer_on <= 1'b0;
        wait_on(1, 1'b1);
        rd(OFS_IRQ, 32'h8);
        wait_on(1, 1'b0); // Line drops once read.
    endtask : s_collision
    task automatic s_target();
        wr(OFS_MODE, 32'h5); // Target with rate detection.
        wr(OFS_OPCTRL, 32'h0);
        wait_on(3, 1'b1); // Low power target.
        @(posedge clk) peer_on <= 1'b1;
        wait_on(1, 1'b1);
        rd(OFS_IRQ, 32'h4); // Initiator field seen.
        wr(OFS_OPCTRL, 32'h7); // Power up first.
        wr(OFS_CMD, 32'(CMD_START_MASK_RX)); // Then mask timer.
        wait_on(2, 1'b1);
        @(posedge clk) rx_start <= 1'b1;
        @(posedge clk) begin
            rx_start <= 1'b0;
            rate_valid <= 1'b1;
            rate_code <= RATE_FC32;
        end
        @(posedge clk) rate_valid <= 1'b0;
        rd(OFS_IRQ, 32'hc0); // Start and rate flags.
        rd(OFS_DETRATE, 32'h6); // Rate measured.
        wr(OFS_CMD, 32'(CMD_GO_NORMAL));
        rd(OFS_MODE, 32'h11); // Rate copied, normal mode.
        chk(32'(rate), 32'(RATE_FC32)); // One shared rate.
        @(posedge clk) peer_on <= 1'b0;
        wait_on(2, 1'b0);
        wr(OFS_OPCTRL, 32'h0); // Back to low power.
        wr(OFS_MODE, 32'h5); // Rate detection again.
        wait_on(3, 1'b1); // Low power again.
        wr(OFS_AUX, 32'h1e);
        wr(OFS_CMD, 32'(CMD_RESPONSE_FIELD_ON));
        repeat (CA_CYC + 2 * RCA_CYC) @(posedge clk);
        chk(32'(txe), 32'h0);
        repeat (3) @(posedge clk);
        chk(32'(txe), 32'h1);
    endtask : s_target
    initial begin
        {awv, wv, bready, arv, rready, peer_on, rx_start, rate_valid, rate_code} = '0;
        {awa, ara, wdata} = '0;
        wstrb = 4'hf;
        reset_n = 1'b0;
        {n_mismatch, n_compared, cycles} = '0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        s_regs();
        s_initiator();
        s_collision();
        s_target();
        final_report();
    end
endmodule : nfc_active_p2p_field_sequencer_tb_top
bind nfc_active_p2p_field_sequencer nfc_seq_chk chk_i (.clk(clk), .reset_n(reset_n),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .tx_enable(tx_enable),
    .ca_threshold_select(ca_threshold_select), .rx_observe(rx_observe),
    .low_power(low_power), .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid),
    .tx_payload_go(tx_payload_go));
